// ---- design/mic_pkg.sv ----
// Shared constants and carrier types of the interrupt controller
package mic_pkg;
  // ----------------------------------------
  // Register byte addresses
  // ----------------------------------------
  localparam logic [7:0] OFS_EN_HIGH = 8'h00;
  localparam logic [7:0] OFS_EN_MID = 8'h04;
  localparam logic [7:0] OFS_EN_LOW = 8'h08;
  localparam logic [7:0] OFS_RQ_HIGH = 8'h0c;
  localparam logic [7:0] OFS_RQ_MID = 8'h10;
  localparam logic [7:0] OFS_RQ_LOW = 8'h14;
  localparam logic [7:0] OFS_PF_HIGH = 8'h18;
  localparam logic [7:0] OFS_PF_LOW = 8'h1c;
  localparam logic [7:0] OFS_STATUS = 8'h20;
  localparam logic [7:0] OFS_KEY_EN = 8'h24;
  localparam logic [7:0] OFS_SEQ = 8'h28;
  localparam logic [7:0] OFS_EDGE_SEL = 8'hfc;
  // ----------------------------------------
  // Field positions and reset values
  // ----------------------------------------
  localparam int ST_IE = 2;   // Master enable in status word
  localparam int ST_BRK = 4;  // Break flag in status word
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [23:0] RST_FLAGS = 24'h000000;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  // Source bits: {high,mid,low}; higher bit wins arbitration
  localparam int SRC_KS = 23;
  localparam int SRC_EXT0 = 22;
  localparam int SRC_EXT1 = 21;
  localparam int SRC_EXT2 = 20;
  localparam int SRC_RX0 = 19;
  localparam int SRC_TX0 = 18;
  localparam int SRC_RX1 = 17;
  localparam int SRC_TX1 = 16;
  localparam int SRC_T0 = 15;
  localparam int SRC_T1 = 14;
  localparam int SRC_T2 = 13;
  localparam int SRC_T3 = 12;
  localparam int SRC_CG = 11;
  localparam int SRC_ADC = 10;
  localparam int SRC_BIT = 9;
  localparam int SRC_WDT = 8;
  localparam int SRC_WT = 7;
  localparam logic [23:0] SRC_MASK = 24'hffff80;
  localparam logic [23:0] EDGE_SRC = 24'h700000;
  // Edge select codes per pin
  localparam logic [1:0] EDGE_OFF = 2'b00;
  localparam logic [1:0] EDGE_FALL = 2'b01;
  localparam logic [1:0] EDGE_RISE = 2'b10;
  localparam logic [1:0] EDGE_BOTH = 2'b11;
  // Acceptance takes 8 periods of the 8 ns clock
  localparam int ACC_NS = 64;
  localparam int CLK_NS = 8;
  localparam int ACC_CYC = ACC_NS / CLK_NS;
  // Break shares the table-call-zero entry; value arbitrary
  localparam logic [15:0] VEC_BRK = 16'hffde;
  localparam logic [15:0] VEC_NONE = 16'hffde;

  // ----------------------------------------
  // Carrier types
  // ----------------------------------------
  typedef struct packed {
    logic push;       // One byte onto the stack
    logic [7:0] data; // Byte pushed
  } mic_stack_s;
  typedef struct packed {
    logic load;        // Program counter load pulse
    logic [15:0] addr; // Vector entry
  } mic_pc_s;

  // Vector table by source bit
  function automatic logic [15:0] micVector(input logic [4:0] src);
    unique case (src)
      5'd23: micVector = 16'hfffc;
      5'd22: micVector = 16'hfffa;
      5'd21: micVector = 16'hfff8;
      5'd20: micVector = 16'hfff6;
      5'd19: micVector = 16'hfff4;
      5'd18: micVector = 16'hfff2;
      5'd17, 5'd16: micVector = 16'hfff0;
      5'd15: micVector = 16'hffee;
      5'd14: micVector = 16'hffec;
      5'd13: micVector = 16'hffea;
      5'd12: micVector = 16'hffe8;
      5'd11: micVector = 16'hffe6;
      5'd10: micVector = 16'hffe4;
      5'd9: micVector = 16'hffe2;
      5'd8: micVector = 16'hffe0;
      default: micVector = VEC_NONE;
    endcase
  endfunction : micVector
endpackage : mic_pkg

// ---- design/mic_edge_det.sv ----
// External pin synchroniser with selectable edge detection
`timescale 1ns/1ps
module mic_edge_det
  import mic_pkg::*;
(
  input wire logic mclk,     // System clock
  input wire logic sys_rst,  // Synchronous reset
  input wire logic pin,      // Asynchronous pin
  input wire logic [1:0] sel, // Edge select code
  output logic hit           // One-cycle edge event
);
  // ----------------------------------------
  // Synchroniser and history
  // ----------------------------------------
  logic meta_q; // First stage, read only by second
  logic sync_q; // Second stage
  logic last_q; // Previous synced level

  // Two flops before logic, third keeps history
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      meta_q <= 1'b1;
      sync_q <= 1'b1;
      last_q <= 1'b1;
    end else begin
      meta_q <= pin;
      sync_q <= meta_q;
      last_q <= sync_q;
    end
  end

  // Edge qualification by select code
  always_comb begin
    unique case (sel)
      EDGE_FALL: hit = last_q & ~sync_q;
      EDGE_RISE: hit = ~last_q & sync_q;
      EDGE_BOTH: hit = last_q ^ sync_q;
      default: hit = 1'b0;
    endcase
  end
endmodule : mic_edge_det

// ---- design/mic_prio_enc.sv ----
// Fixed-priority encoder over the request vector
`timescale 1ns/1ps
module mic_prio_enc (
  input wire logic [23:0] cand, // Eligible requests
  output logic found,           // Any eligible
  output logic [4:0] idx        // Winning bit
);
  // Later iterations overwrite: highest bit wins, ties by bit order
  always_comb begin
    found = 1'b0;
    idx = 5'd0;
    for (int i = 0; i < 24; i++) begin
      if (cand[i]) begin
        found = 1'b1;
        idx = 5'(i);
      end
    end
  end
endmodule : mic_prio_enc

// ---- design/mic_ctrl.sv ----
// Interrupt controller top: flags, arbitration, acceptance, AXI4-Lite
//
// The AXI4-Lite register port is this design's own decision.
`timescale 1ns/1ps

module mic_ctrl
  import mic_pkg::*;
(
  input wire logic mclk,               // System clock
  input wire logic sys_rst,            // Synchronous reset
  input wire logic [2:0] extPin,       // External interrupt pins
  input wire logic [7:0] keyPin,       // Key scan pins
  input wire logic serial0RxDone,      // Serial 0 receive done
  input wire logic serial0TxDone,      // Serial 0 transmit done
  input wire logic serial1RxDone,      // Serial 1 receive done
  input wire logic serial1TxDone,      // Serial 1 transmit done
  input wire logic [3:0] timerMatch,   // Timer a..d compare match
  input wire logic carrierGenEvent,    // Carrier generator event
  input wire logic converterDone,      // Conversion finished
  input wire logic intervalOverflow,   // Interval timer overflow
  input wire logic watchdogMatch,      // Watchdog match
  input wire logic watchdogResetSelect, // Watchdog acts as reset
  input wire logic watchTick,          // Watch timer interval
  input wire logic instrDone,          // Core instruction boundary
  input wire logic [15:0] retAddr,     // Return address to save
  input wire logic softwareBreak,      // Break instruction pulse
  input wire logic enableIntrInstr,    // Enable instruction pulse
  input wire logic returnFromInt,      // Return instruction pulse
  input wire logic [7:0] poppedStatus, // Status word from stack
  output mic_stack_s stackOut,         // Stack push strobe
  output mic_pc_s pcOut,               // Program counter load
  output logic spDec,                  // Stack pointer decrement
  output logic accBusy,                // Acceptance in progress
  output logic [7:0] statusWord,       // Status word
  input wire logic [7:0] s_axi_awaddr, // Write address
  input wire logic s_axi_awvalid,      // Write address valid
  output logic s_axi_awready,          // Write address ready
  input wire logic [31:0] s_axi_wdata, // Write data
  input wire logic [3:0] s_axi_wstrb,  // Write strobes
  input wire logic s_axi_wvalid,       // Write data valid
  output logic s_axi_wready,           // Write data ready
  output logic [1:0] s_axi_bresp,      // Write response
  output logic s_axi_bvalid,           // Write response valid
  input wire logic s_axi_bready,       // Write response ready
  input wire logic [7:0] s_axi_araddr, // Read address
  input wire logic s_axi_arvalid,      // Read address valid
  output logic s_axi_arready,          // Read address ready
  output logic [31:0] s_axi_rdata,     // Read data
  output logic [1:0] s_axi_rresp,      // Read response
  output logic s_axi_rvalid,           // Read data valid
  input wire logic s_axi_rready        // Read data ready
);
  // ----------------------------------------
  // Acceptance states
  // ----------------------------------------
  typedef enum logic [8:0] {
    S_IDLE = 9'b000000001,
    S_SNAP = 9'b000000010,
    S_CLRIE = 9'b000000100,
    S_CLRRQ = 9'b000001000,
    S_PSHH = 9'b000010000,
    S_PSHL = 9'b000100000,
    S_PSHP = 9'b001000000,
    S_FETCH = 9'b010000000,
    S_LOAD = 9'b100000000
  } mic_state_e;

  mic_state_e state_q; // Sequence state
  mic_state_e state_d; // Next state
  logic [23:0] en_q; // Enable bits
  logic [23:0] rq_q; // Request flags
  logic [23:0] pf_q; // Pending flags
  logic [7:0] edge_q; // Edge select
  logic [7:0] key_en_q; // Key scan enables
  logic [7:0] st_q; // Status word
  logic brk_q; // Break awaiting service
  logic brk_sel_q; // Break chosen this round
  logic [4:0] win_q; // Accepted source bit
  logic [15:0] ret_q; // Captured return address
  logic [2:0] acc_cnt_q; // Cycle count of sequence
  logic [2:0] extHit; // Pin edge events
  logic [7:0] key_m_q; // Key sync stage one
  logic [7:0] key_s_q; // Key sync stage two
  logic [23:0] srcSet; // Hardware set this cycle
  logic [23:0] cand; // Eligible for acceptance
  logic found; // Any eligible
  logic [4:0] idx; // Winner bit
  logic [7:0] awaddr_q; // Latched write address
  logic [31:0] wdata_q; // Latched write data
  logic wstrb0_q; // Low lane strobe
  logic wrDo; // Register write this cycle
  logic wrHit; // Write address mapped

  // ----------------------------------------
  // Source capture and arbitration
  // ----------------------------------------
  for (genvar g = 0; g < 3; g++) begin : g_ext
    mic_edge_det u_edge (.mclk(mclk), .sys_rst(sys_rst), .pin(extPin[g]), .sel(edge_q[2*g+1 -: 2]),
      .hit(extHit[g]));
  end

  // Key pins cross in via two flops
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      key_m_q <= 8'hff;
      key_s_q <= 8'hff;
    end else begin
      key_m_q <= keyPin;
      key_s_q <= key_m_q;
    end
  end

  // Set terms, independent of en_q but key term gated by key_en_q; order follows the source bit layout
  assign srcSet = {|(~key_s_q & key_en_q), extHit[0], extHit[1], extHit[2],
    serial0RxDone, serial0TxDone, serial1RxDone, serial1TxDone,
    timerMatch[0], timerMatch[1], timerMatch[2], timerMatch[3], carrierGenEvent,
    converterDone, intervalOverflow,
    // Watchdog in reset mode raises no interrupt
    watchdogMatch & ~watchdogResetSelect, watchTick, 7'h00};

  // Only enabled sources with master enable compete
  assign cand = st_q[ST_IE] ? (rq_q & en_q & SRC_MASK) : RST_FLAGS;
  mic_prio_enc u_prio (.cand(cand), .found(found), .idx(idx));

  // ----------------------------------------
  // Acceptance sequence
  // ----------------------------------------
  // Starts only on an instruction boundary
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      S_IDLE: if (instrDone && (found || brk_q)) state_d = S_SNAP;
      S_SNAP: state_d = S_CLRIE;
      S_CLRIE: state_d = S_CLRRQ;
      S_CLRRQ: state_d = S_PSHH;
      S_PSHH: state_d = S_PSHL;
      S_PSHL: state_d = S_PSHP;
      S_PSHP: state_d = S_FETCH;
      S_FETCH: state_d = S_LOAD;
      S_LOAD: state_d = S_IDLE;
      default: state_d = S_IDLE;
    endcase
  end

  // State register
  always_ff @(posedge mclk) begin
    if (sys_rst) state_q <= S_IDLE;
    else state_q <= state_d;
  end

  // Winner snapshot; break only when nothing maskable waits
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      win_q <= 5'd0;
      brk_sel_q <= 1'b0;
      ret_q <= 16'h0000;
      acc_cnt_q <= 3'd0;
    end else if (state_q == S_IDLE && state_d == S_SNAP) begin
      win_q <= idx;
      brk_sel_q <= ~found;
      ret_q <= retAddr;
      acc_cnt_q <= 3'd0;
    end else if (state_q != S_IDLE) begin
      acc_cnt_q <= acc_cnt_q + 3'd1;
    end
  end

  // Break request waits here until serviced
  always_ff @(posedge mclk) begin
    if (sys_rst) brk_q <= 1'b0;
    else if (softwareBreak) brk_q <= 1'b1;
    else if (state_q == S_CLRRQ && brk_sel_q) brk_q <= 1'b0;
  end

  // Stack pushes: high, low, then status word
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      stackOut <= '0;
      spDec <= 1'b0;
    end else begin
      stackOut.push <= state_q inside {S_PSHH, S_PSHL, S_PSHP};
      spDec <= state_q inside {S_PSHH, S_PSHL, S_PSHP};
      unique case (state_q)
        S_PSHH: stackOut.data <= ret_q[15:8];
        S_PSHL: stackOut.data <= ret_q[7:0];
        S_PSHP: stackOut.data <= st_q;
        default: stackOut.data <= stackOut.data;
      endcase
    end
  end

  // Vector load ends the sequence; the handler runs next
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      pcOut <= '0;
      accBusy <= 1'b0;
    end else begin
      pcOut.load <= (state_q == S_LOAD);
      if (state_q == S_FETCH) pcOut.addr <= brk_sel_q ? VEC_BRK : micVector(win_q);
      accBusy <= (state_d != S_IDLE);
    end
  end

  // Status word: sequence clears master enable first; return restores all
  always_ff @(posedge mclk) begin
    if (sys_rst) st_q <= RST_BYTE;
    else if (state_q == S_CLRIE) begin
      st_q[ST_IE] <= 1'b0;
      st_q[ST_BRK] <= brk_sel_q;
    end else if (returnFromInt) st_q <= poppedStatus;
    else if (enableIntrInstr) st_q[ST_IE] <= 1'b1;
    else if (wrDo && awaddr_q == OFS_STATUS) st_q <= wdata_q[7:0];
  end
  assign statusWord = st_q;

  // ----------------------------------------
  // Flags
  // ----------------------------------------
  // Request flags hold until written, or accepted for edge sources only; set wins
  always_ff @(posedge mclk) begin
    logic [23:0] nxt;
    nxt = rq_q;
    if (sys_rst) begin
      rq_q <= RST_FLAGS;
    end else begin
      if (state_q == S_CLRRQ && !brk_sel_q && EDGE_SRC[win_q]) nxt[win_q] = 1'b0;
      if (wrDo && awaddr_q == OFS_RQ_HIGH) nxt[23:16] = wdata_q[7:0];
      if (wrDo && awaddr_q == OFS_RQ_MID) nxt[15:8] = wdata_q[7:0];
      if (wrDo && awaddr_q == OFS_RQ_LOW) nxt[7:0] = wdata_q[7:0];
      rq_q <= (nxt | srcSet) & SRC_MASK;
    end
  end

  // Pending flags: sticky, cleared only by software; bit 7 has no write byte and only reset clears it
  always_ff @(posedge mclk) begin
    logic [23:0] nxt;
    nxt = pf_q;
    if (sys_rst) begin
      pf_q <= RST_FLAGS;
    end else begin
      if (wrDo && awaddr_q == OFS_PF_HIGH) nxt[23:16] = wdata_q[7:0];
      if (wrDo && awaddr_q == OFS_PF_LOW) nxt[15:8] = wdata_q[7:0];
      pf_q <= (nxt | (rq_q & en_q)) & SRC_MASK;
    end
  end

  // Configuration registers
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      en_q <= RST_FLAGS;
      edge_q <= RST_BYTE;
      key_en_q <= RST_BYTE;
    end else if (wrDo) begin
      unique case (awaddr_q)
        OFS_EN_HIGH: en_q[23:16] <= wdata_q[7:0];
        OFS_EN_MID: en_q[15:8] <= wdata_q[7:0];
        OFS_EN_LOW: en_q[7:0] <= wdata_q[7:0] & SRC_MASK[7:0];
        OFS_EDGE_SEL: edge_q <= wdata_q[7:0];
        OFS_KEY_EN: key_en_q <= wdata_q[7:0];
        default: ;
      endcase
    end
  end

  // ----------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------
  // Address and data are taken in either order; one at a time
  assign wrHit = awaddr_q inside {OFS_EN_HIGH, OFS_EN_MID, OFS_EN_LOW, OFS_RQ_HIGH,
    OFS_RQ_MID, OFS_RQ_LOW, OFS_PF_HIGH, OFS_PF_LOW, OFS_STATUS, OFS_KEY_EN, OFS_EDGE_SEL};
  assign wrDo = ~s_axi_awready & ~s_axi_wready & ~s_axi_bvalid & wstrb0_q & wrHit;

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h00000000;
      wstrb0_q <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awaddr_q <= {s_axi_awaddr[7:2], 2'b00};
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wdata_q <= s_axi_wdata;
        wstrb0_q <= s_axi_wstrb[0];
        s_axi_wready <= 1'b0;
      end
      if (!s_axi_awready && !s_axi_wready && !s_axi_bvalid) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wrHit ? RESP_OKAY : RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // Read mux; the sequence register shows the controller's own state
  function automatic logic [31:0] readMux(input logic [7:0] a);
    unique case (a)
      OFS_EN_HIGH: readMux = {24'h000000, en_q[23:16]};
      OFS_EN_MID: readMux = {24'h000000, en_q[15:8]};
      OFS_EN_LOW: readMux = {24'h000000, en_q[7:0]};
      OFS_RQ_HIGH: readMux = {24'h000000, rq_q[23:16]};
      OFS_RQ_MID: readMux = {24'h000000, rq_q[15:8]};
      OFS_RQ_LOW: readMux = {24'h000000, rq_q[7:0]};
      OFS_PF_HIGH: readMux = {24'h000000, pf_q[23:16]};
      OFS_PF_LOW: readMux = {24'h000000, pf_q[15:8]};
      OFS_STATUS: readMux = {24'h000000, st_q};
      OFS_KEY_EN: readMux = {24'h000000, key_en_q};
      OFS_SEQ: readMux = {12'h000, state_q, brk_q, brk_sel_q, acc_cnt_q, win_q, accBusy};
      OFS_EDGE_SEL: readMux = {24'h000000, edge_q};
      default: readMux = 32'h00000000;
    endcase
  endfunction : readMux

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= readMux({s_axi_araddr[7:2], 2'b00});
      s_axi_rresp <= ({s_axi_araddr[7:2], 2'b00} inside {OFS_EN_HIGH, OFS_EN_MID, OFS_EN_LOW,
        OFS_RQ_HIGH, OFS_RQ_MID, OFS_RQ_LOW, OFS_PF_HIGH, OFS_PF_LOW, OFS_STATUS,
        OFS_KEY_EN, OFS_SEQ, OFS_EDGE_SEL}) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end
endmodule : mic_ctrl

// ---- tb/mic_ctrl_props.sv ----
// Port-level assertion checker for the interrupt controller
`timescale 1ns/1ps
module mic_ctrl_props
  import mic_pkg::*;
(
  input wire logic mclk, // Clock
  input wire logic sys_rst, // Reset
  input wire mic_stack_s stackOut, // Push strobe
  input wire mic_pc_s pcOut, // Vector load
  input wire logic spDec, // Stack decrement
  input wire logic accBusy, // Sequence busy
  input wire logic [7:0] statusWord, // Status word
  input wire logic s_axi_awvalid, // Write address valid
  input wire logic s_axi_awready, // Write address ready
  input wire logic s_axi_wvalid, // Write data valid
  input wire logic s_axi_wready, // Write data ready
  input wire logic s_axi_bvalid, // Response valid
  input wire logic s_axi_bready, // Response ready
  input wire logic s_axi_arvalid, // Read address valid
  input wire logic s_axi_arready, // Read address ready
  input wire logic s_axi_rvalid // Read data valid
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  // ------------------------------
  // Helpers
  // ------------------------------
  logic [3:0] pushCnt_q; // Pushes since the last vector load
  // Cleared by each load so every sequence is counted on its own
  always_ff @(posedge mclk) begin
    if (sys_rst || pcOut.load) pushCnt_q <= 4'h0;
    else if (stackOut.push) pushCnt_q <= pushCnt_q + 4'h1;
  end
  sequence accStartS;
    $rose(accBusy);
  endsequence
  sequence wrTakenS;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  AST_PUSH_DEC: assert property (stackOut.push == spDec)
    else $error("push and decrement differ");
  AST_THREE_PUSH: assert property (pcOut.load |-> pushCnt_q == 4'h3)
    else $error("push count at load wrong");
  AST_LOAD_TIME: assert property (accStartS |-> ##[7:8] pcOut.load)
    else $error("vector load late");
  AST_BUSY_HOLD: assert property (accStartS |-> accBusy [*7])
    else $error("busy dropped early");
  AST_IE_OFF: assert property (pcOut.load |-> !statusWord[ST_IE])
    else $error("master enable still set");
  AST_LOAD_PULSE: assert property (pcOut.load |=> !pcOut.load && !accBusy[*1])
    else $error("load not a pulse");
  AST_ADDR_HOLD: assert property (pcOut.load |-> $stable(pcOut.addr))
    else $error("vector moved at load");
  AST_WR_RESP: assert property (wrTakenS |-> ##2 s_axi_bvalid)
    else $error("write response late");
  AST_B_DONE: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("response not retired");
  AST_RD_RESP: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read answer late");
endmodule : mic_ctrl_props
bind mic_ctrl mic_ctrl_props mic_ctrl_props_i (.*);

// ---- tb/mic_core_model.sv ----
// Behavioural processor core facing the acceptance interface
`timescale 1ns/1ps
module mic_core_model
  import mic_pkg::*;
(
  input wire logic mclk, // Clock
  input wire logic sys_rst, // Reset
  input wire logic slow, // Long instructions
  input wire mic_stack_s stackIn, // Stack pushes
  input wire mic_pc_s pcIn, // Vector load
  output logic instrDone, // Instruction boundary
  output int loadCnt, // Loads seen
  output int pushCnt, // Pushes seen
  output logic [15:0] lastAddr, // Last vector
  output logic [7:0] lastByte // Last pushed byte
);
  logic [1:0] div_q; // Instruction length counter
  always_ff @(posedge mclk) begin
    if (sys_rst) div_q <= 2'h0;
    else div_q <= div_q + 2'h1;
  end
  // Slow mode ends an instruction only every fourth cycle
  assign instrDone = slow ? (div_q == 2'h3) : 1'b1;
  // Record the stack and program counter traffic
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      loadCnt <= 0;
      pushCnt <= 0;
    end else begin
      if (stackIn.push) pushCnt <= pushCnt + 1;
      if (stackIn.push) lastByte <= stackIn.data;
      if (pcIn.load) loadCnt <= loadCnt + 1;
      if (pcIn.load) lastAddr <= pcIn.addr;
    end
  end
endmodule : mic_core_model

// ---- tb/testbench.sv ----
// Self-checking bench for the interrupt controller
`timescale 1ns/1ps
module testbench;
  import mic_pkg::*;
  typedef struct packed {logic [12:0] ev; logic [23:0] exp;} mic_row_s; // Event and flags
  logic mclk, sys_rst, serial0RxDone, serial0TxDone, serial1RxDone, serial1TxDone, slow;
  logic carrierGenEvent, converterDone, intervalOverflow, watchdogMatch, watchTick, spDec, accBusy;
  logic watchdogResetSelect, instrDone, softwareBreak, enableIntrInstr, returnFromInt;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [2:0] extPin;
  logic [3:0] timerMatch, s_axi_wstrb;
  logic [7:0] keyPin, poppedStatus, statusWord, s_axi_awaddr, s_axi_araddr, h, m, l, lastByte;
  logic [15:0] retAddr, lastAddr;
  logic [12:0] ev;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [1:0] s_axi_bresp, s_axi_rresp, rresp, c;
  mic_stack_s stackOut;
  mic_pc_s pcOut;
  mic_row_s rows [10];
  int err_count, n_tests, cycles, loadCnt, pushCnt, i;
  assign {serial0RxDone, serial0TxDone, serial1RxDone, serial1TxDone, timerMatch, carrierGenEvent,
    converterDone, intervalOverflow, watchdogMatch, watchTick} = ev;
  mic_ctrl mic_ctrl_i (.*);
  mic_core_model mic_core_model_i (.mclk, .sys_rst, .slow, .stackIn(stackOut), .pcIn(pcOut),
    .instrDone, .loadCnt, .pushCnt, .lastAddr, .lastByte);
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  // ------------------------------
  // Shared tasks
  // ------------------------------
  task automatic complete_run;
    if (err_count == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : complete_run
  task automatic chk(input string n, input logic [23:0] e, input logic [23:0] s);
    n_tests++;
    if (s !== e) begin
      $display("mismatch %s expected %h seen %h", n, e, s);
      err_count++;
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask : cyc
  // Offer address and data together, hold each until taken
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h000000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge mclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge mclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata[7:0];
    rresp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : rd
  // Hang guard: the sequence needs a few hundred cycles
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      complete_run();
    end
  end
  // ------------------------------
  // Main sequence
  // ------------------------------
  initial begin
    rows = '{'{13'h1000, 24'h080000}, '{13'h0800, 24'h040000}, '{13'h0400, 24'h020000},
      '{13'h0200, 24'h010000}, '{13'h01e0, 24'h00f000}, '{13'h0010, 24'h000800},
      '{13'h0008, 24'h000400}, '{13'h0004, 24'h000200}, '{13'h0002, 24'h000100}, '{13'h0001, 24'h000080}};
    {ev, extPin, watchdogResetSelect, softwareBreak, enableIntrInstr, returnFromInt, slow} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, s_axi_awaddr} = '0;
    {s_axi_araddr, s_axi_wdata, poppedStatus} = '0;
    keyPin = 8'hff;
    retAddr = 16'h1234;
    s_axi_wstrb = 4'hf;
    sys_rst = 1'b1;
    cyc(2);
    sys_rst <= 1'b0;
    for (i = 0; i < 10; i++) begin
      rd(8'(i * 4), h);
      chk("reset value", 24'h0, h);
    end
    rd(8'h40, h);
    chk("unmapped response", 24'(RESP_SLVERR), rresp);
    wr(8'h40, 8'h00);
    chk("unmapped write", 24'(RESP_SLVERR), s_axi_bresp);
    for (i = 0; i < 10; i++) begin
      @(posedge mclk);
      ev <= rows[i].ev;
      @(posedge mclk);
      ev <= '0;
      rd(OFS_RQ_HIGH, h);
      rd(OFS_RQ_MID, m);
      rd(OFS_RQ_LOW, l);
      chk("request flags", rows[i].exp, {h, m, l});
      wr(OFS_RQ_HIGH, 8'h00);
      wr(OFS_RQ_MID, 8'h00);
      wr(OFS_RQ_LOW, 8'h00);
      chk("write response", 24'(RESP_OKAY), s_axi_bresp);
    end
    // Watchdog used as reset raises no flag
    watchdogResetSelect <= 1'b1;
    ev <= 13'h0002;
    cyc(1);
    ev <= '0;
    rd(OFS_RQ_MID, m);
    chk("watchdog as reset", 24'h0, m);
    wr(OFS_KEY_EN, 8'h01);
    keyPin <= 8'hfe;
    cyc(6);
    rd(OFS_RQ_HIGH, h);
    chk("key flag", 24'h80, h);
    keyPin <= 8'hff;
    cyc(6);
    wr(OFS_RQ_HIGH, 8'h00);
    for (i = 1; i < 4; i++) begin
      c = 2'(i);
      wr(OFS_EDGE_SEL, {2'b00, c, c, c});
      extPin <= 3'h7;
      cyc(8);
      rd(OFS_RQ_HIGH, h);
      chk("rising flags", {1'b0, {3{c[1]}}, 4'h0}, h);
      wr(OFS_RQ_HIGH, 8'h00);
      extPin <= 3'h0;
      cyc(8);
      rd(OFS_RQ_HIGH, h);
      chk("falling flags", {1'b0, {3{c[0]}}, 4'h0}, h);
      wr(OFS_RQ_HIGH, 8'h00);
    end
    // Ext0 and timer a pend together; master enable still off
    wr(OFS_EN_HIGH, 8'h40);
    wr(OFS_EN_MID, 8'h80);
    ev <= 13'h01e0;
    extPin <= 3'h1;
    cyc(1);
    ev <= '0;
    cyc(20);
    chk("blocked while disabled", 24'h0, loadCnt);
    enableIntrInstr <= 1'b1;
    cyc(1);
    enableIntrInstr <= 1'b0;
    while (loadCnt < 1) @(posedge mclk);
    chk("ext0 vector", 24'hfffa, lastAddr);
    chk("three pushes", 24'h3, pushCnt);
    chk("master enable", 24'h0, statusWord[ST_IE]);
    rd(OFS_RQ_HIGH, h);
    chk("edge flag cleared", 24'h0, h);
    rd(OFS_PF_HIGH, h);
    chk("sticky pending", 24'h40, h);
    rd(OFS_RQ_MID, m);
    chk("timer flags held", 24'hf0, m);
    chk("no nesting", 24'h1, loadCnt);
    softwareBreak <= 1'b1;
    cyc(1);
    softwareBreak <= 1'b0;
    while (loadCnt < 2) @(posedge mclk);
    chk("break vector", 24'(VEC_BRK), lastAddr);
    chk("break flag pushed", 24'h1, lastByte[ST_BRK]);
    wr(OFS_EN_MID, 8'h00);
    poppedStatus <= 8'h04;
    returnFromInt <= 1'b1;
    cyc(1);
    returnFromInt <= 1'b0;
    cyc(2);
    chk("restored status", 24'h04, statusWord);
    slow <= 1'b1;
    wr(OFS_EN_MID, 8'h80);
    while (loadCnt < 3) @(posedge mclk);
    chk("timer a vector", 24'hffee, lastAddr);
    rd(OFS_RQ_MID, m);
    chk("level flag kept", 24'hf0, m);
    complete_run();
  end
endmodule : testbench
